// file: logic/wps_word_pattern_store.sv
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Basic build holds an 8-bit or 16-bit current word, one or two bytes.
// - With extended memory, current and saved words hold up to 512 kbit.
// - Ten save slots plus current word, their bytes kept in storage that is never reset.
// - Fill writes one eight-bit value into every byte of the word.
// - Bit order picks MSB-first or LSB-first per byte for serial output.
// - Sync pulse output marks the programmed byte location in the pattern.
// - Edit byte address ranges 0..8192 at 64k, 0..16384 at 128k buffers.
// - Length is bytes plus extra bits up to 2048 bytes, whole bytes above.
// - Toggle selector 1 flips the MSB, selector 8 flips the LSB.
// - Length, fill and edits stay pending until commit; abort discards them.
// - Recallable slots depend on partition; ten 64k buffers give slots 0..9.
// - Store holds a programmable BER threshold for pattern synchronization, driven out on ber_threshold.
// - Bytes committed to the current word survive reset without a save; its length resets to two bytes.
// - Extended memory splits as 10x64k, 6x128k, 3x256k or 1x512k segments.
// - Only one editing session may be open at any time.
module wps_word_pattern_store (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [wps_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [wps_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic ser_data,
  output logic ser_sync,
  output logic ser_valid,
  input wire logic ser_ready,
  output logic [31:0] ber_threshold
);
  import wps_pkg::*;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_held;
    logic w_held;
    logic [AXI_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    wps_len_t cur_len;
    wps_len_t scr_len;
    wps_len_t [NUM_SLOTS-1:0] slot_len;
    logic [16:0] edit_addr;
    logic [16:0] sync_loc;
    logic [31:0] ber_thr;
    logic session;
    logic err;
    wps_eng_t eng;
    logic eng_fill;
    logic [7:0] fill_val;
    logic [17:0] src;
    logic [17:0] dst;
    logic [16:0] cnt;
    logic [16:0] ptr_byte;
    logic [2:0] ptr_bit;
  } wps_state_t;

  function automatic logic [16:0] seg_bytes(input logic ext, input logic [1:0] part);
    if (!ext) begin
      return BASIC_WORD_BYTES;
    end
    unique case (part)
      2'h0: return SEG64_BYTES;
      2'h1: return SEG128_BYTES;
      2'h2: return SEG256_BYTES;
      2'h3: return SEG512_BYTES;
    endcase
  endfunction : seg_bytes

  function automatic logic [3:0] slots_avail(input logic ext, input logic [1:0] part);
    if (!ext) begin
      return SLOTS_64K;
    end
    unique case (part)
      2'h0: return SLOTS_64K;
      2'h1: return SLOTS_128K;
      2'h2: return SLOTS_256K;
      2'h3: return SLOTS_512K;
    endcase
  endfunction : slots_avail

  function automatic logic [17:0] slot_base(input logic [3:0] slot, input logic [16:0] seg);
    return 18'(SAVE_BASE + 18'(slot) * 18'(seg));
  endfunction : slot_base

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  wps_state_t s;
  wps_state_t next_s;
  logic [7:0] mem [MEM_BYTES];
  logic mem_we;
  logic [17:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic ext;
  logic [1:0] part;
  logic [16:0] seg;
  logic [3:0] nslots;
  logic wr_fire;
  logic [3:0] arg;
  logic arg_ok;
  wps_len_t wl;
  logic start_job;
  logic job_fill;
  logic [17:0] job_src;
  logic [17:0] job_dst;
  logic [7:0] edit_byte;
  logic [7:0] ser_byte;
  logic [16:0] last_byte;
  logic [2:0] last_bit;
  logic buf_in_ready;
  logic ser_push;

  assign ext = s.ctrl[CTRL_EXT_MEM];
  assign part = s.ctrl[CTRL_PART_LO +: 2];
  assign seg = seg_bytes(ext, part);
  assign nslots = slots_avail(ext, part);
  assign edit_byte = mem[(s.session ? SCR_BASE : CUR_BASE) + 18'(s.edit_addr)];
  assign ser_byte = mem[CUR_BASE + 18'(s.ptr_byte)];
  assign last_byte = (s.cur_len.bits != 3'h0) ? s.cur_len.bytes : s.cur_len.bytes - 17'h00001;
  assign last_bit = (s.cur_len.bits != 3'h0) ? s.cur_len.bits - 3'h1 : 3'h7;
  assign ser_push = s.ctrl[CTRL_RUN] && buf_in_ready;

  always_comb begin
    next_s = s;
    mem_we = 1'h0;
    mem_waddr = CUR_BASE;
    mem_wdata = 8'h00;
    arg = s.wdata[ARG_LO +: 4];
    arg_ok = (arg == ARG_CURRENT) || (arg < nslots);
    start_job = 1'h0;
    job_fill = 1'h0;
    job_src = CUR_BASE;
    job_dst = SCR_BASE;
    wl = '{bits: s.wdata[LEN_BITS_LO +: 3], bytes: s.wdata[16:0]};
    if (!ext) begin
      wl.bits = 3'h0;
      wl.bytes = (wl.bytes > MIN_WORD_BYTES) ? BASIC_WORD_BYTES : MIN_WORD_BYTES;
    end else begin
      if (wl.bytes >= seg) begin
        wl.bytes = seg;
        wl.bits = 3'h0;
      end
      if (wl.bytes > LONG_BITS_MAX_BYTES) begin
        wl.bits = 3'h0;
      end
      if (wl.bytes == 17'h00000 && wl.bits == 3'h0) begin
        wl.bytes = MIN_WORD_BYTES;
      end
    end

    if (s.awready && s_axi_awvalid) begin
      next_s.aw_held = 1'h1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.w_held = 1'h1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'h0;
    end

    // Copy and fill move one byte per cycle; data, toggle and fill writes meanwhile set the error flag.
    if (s.eng == ENG_RUN) begin
      mem_we = 1'h1;
      mem_waddr = s.dst;
      mem_wdata = s.eng_fill ? s.fill_val : mem[s.src];
      next_s.src = s.src + 18'h00001;
      next_s.dst = s.dst + 18'h00001;
      next_s.cnt = s.cnt - 17'h00001;
      if (s.cnt == 17'h00001) begin
        next_s.eng = ENG_IDLE;
      end
    end

    wr_fire = s.aw_held && s.w_held && !s.bvalid;
    if (wr_fire) begin
      next_s.aw_held = 1'h0;
      next_s.w_held = 1'h0;
      next_s.bvalid = 1'h1;
      next_s.bresp = RESP_OKAY;
      unique case (s.awaddr)
        REG_CTRL: next_s.ctrl = merge(s.ctrl, s.wdata, s.wstrb);
        REG_BER_THR: next_s.ber_thr = merge(s.ber_thr, s.wdata, s.wstrb);
        REG_SYNC_LOC: next_s.sync_loc = s.wdata[16:0];
        REG_ADDR: begin
          if (s.wdata[16:0] <= seg) begin
            next_s.edit_addr = s.wdata[16:0];
          end else begin
            next_s.err = 1'h1;
          end
        end
        REG_LENGTH: begin
          if (s.session) begin
            next_s.scr_len = wl;
          end else begin
            next_s.err = 1'h1;
          end
        end
        REG_DATA, REG_TOGGLE: begin
          if (!s.session || s.eng != ENG_IDLE || s.edit_addr >= seg) begin
            next_s.err = 1'h1;
          end else if (s.awaddr == REG_DATA) begin
            mem_we = 1'h1;
            mem_waddr = SCR_BASE + 18'(s.edit_addr);
            mem_wdata = s.wdata[7:0];
          end else if (s.wdata[3:0] >= 4'h1 && s.wdata[3:0] <= 4'h8) begin
            mem_we = 1'h1;
            mem_waddr = SCR_BASE + 18'(s.edit_addr);
            mem_wdata = edit_byte ^ (8'h80 >> (s.wdata[3:0] - 4'h1));
          end else begin
            next_s.err = 1'h1;
          end
        end
        REG_FILL: begin
          if (s.session && s.eng == ENG_IDLE) begin
            start_job = 1'h1;
            job_fill = 1'h1;
            next_s.fill_val = s.wdata[7:0];
          end else begin
            next_s.err = 1'h1;
          end
        end
        REG_STATUS: begin
          if (s.wdata[ST_ERR]) begin
            next_s.err = 1'h0;
          end
        end
        REG_CMD: begin
          unique case (s.wdata[3:0])
            CMD_BEGIN: begin
              if (s.session || s.eng != ENG_IDLE || !arg_ok) begin
                next_s.err = 1'h1;
              end else begin
                start_job = 1'h1;
                next_s.session = 1'h1;
                job_src = (arg == ARG_CURRENT) ? CUR_BASE : slot_base(arg, seg);
                next_s.scr_len = (arg == ARG_CURRENT) ? s.cur_len : s.slot_len[arg];
              end
            end
            CMD_COMMIT: begin
              if (!s.session || s.eng != ENG_IDLE || !arg_ok) begin
                next_s.err = 1'h1;
              end else begin
                start_job = 1'h1;
                next_s.session = 1'h0;
                job_src = SCR_BASE;
                if (arg == ARG_CURRENT) begin
                  job_dst = CUR_BASE;
                  next_s.cur_len = s.scr_len;
                end else begin
                  job_dst = slot_base(arg, seg);
                  next_s.slot_len[arg] = s.scr_len;
                end
              end
            end
            CMD_ABORT: begin
              if (s.session && s.eng == ENG_IDLE) begin
                next_s.session = 1'h0;
              end else begin
                next_s.err = 1'h1;
              end
            end
            CMD_SAVE, CMD_RECALL: begin
              if (s.session || s.eng != ENG_IDLE || arg >= nslots) begin
                next_s.err = 1'h1;
              end else begin
                start_job = 1'h1;
                if (s.wdata[3:0] == CMD_SAVE) begin
                  job_src = CUR_BASE;
                  job_dst = slot_base(arg, seg);
                  next_s.slot_len[arg] = s.cur_len;
                end else begin
                  job_src = slot_base(arg, seg);
                  job_dst = CUR_BASE;
                  next_s.cur_len = s.slot_len[arg];
                end
              end
            end
            default: next_s.err = 1'h1;
          endcase
        end
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end
    if (start_job) begin
      next_s.eng = ENG_RUN;
      next_s.eng_fill = job_fill;
      next_s.src = job_src;
      next_s.dst = job_dst;
      next_s.cnt = seg;
    end
    next_s.awready = !next_s.aw_held;
    next_s.wready = !next_s.w_held;

    if (s.arready && s_axi_arvalid) begin
      next_s.arready = 1'h0;
      next_s.rvalid = 1'h1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        REG_CTRL: next_s.rdata = s.ctrl;
        REG_LENGTH: next_s.rdata = 32'(s.scr_len.bytes) | (32'(s.scr_len.bits) << LEN_BITS_LO);
        REG_CUR_LEN: next_s.rdata = 32'(s.cur_len.bytes) | (32'(s.cur_len.bits) << LEN_BITS_LO);
        REG_ADDR: next_s.rdata = 32'(s.edit_addr);
        REG_DATA: next_s.rdata = (s.edit_addr < seg) ? 32'(edit_byte) : 32'h0000_0000;
        REG_FILL: next_s.rdata = 32'(s.fill_val);
        REG_SYNC_LOC: next_s.rdata = 32'(s.sync_loc);
        REG_BER_THR: next_s.rdata = s.ber_thr;
        REG_STATUS: begin
          next_s.rdata[ST_SESSION] = s.session;
          next_s.rdata[ST_BUSY] = (s.eng == ENG_RUN);
          next_s.rdata[ST_ERR] = s.err;
        end
        REG_TOGGLE, REG_CMD: next_s.rdata = 32'h0000_0000;
        default: next_s.rresp = RESP_SLVERR;
      endcase
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'h0;
      next_s.arready = 1'h1;
    end

    // The pointer wraps even if the length shrank under it.
    if (ser_push) begin
      if (s.ptr_byte > last_byte || (s.ptr_byte == last_byte && s.ptr_bit >= last_bit)) begin
        next_s.ptr_byte = 17'h00000;
        next_s.ptr_bit = 3'h0;
      end else if (s.ptr_bit == 3'h7) begin
        next_s.ptr_byte = s.ptr_byte + 17'h00001;
        next_s.ptr_bit = 3'h0;
      end else begin
        next_s.ptr_bit = s.ptr_bit + 3'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.awready <= 1'h1;
      s.wready <= 1'h1;
      s.arready <= 1'h1;
      s.ctrl <= CTRL_RST;
      s.ber_thr <= BER_THR_RST;
      s.sync_loc <= SYNC_LOC_RST;
      s.cur_len <= LEN_RST;
      s.scr_len <= LEN_RST;
      s.slot_len <= {NUM_SLOTS{LEN_RST}};
      s.eng <= ENG_IDLE;
      s.ptr_byte <= 17'h00000;
      s.ptr_bit <= 3'h0;
    end else begin
      s <= next_s;
    end
  end

  // Pattern storage has no reset so it survives like battery-backed memory.
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  wps_pair_buf #(
    .W(SER_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(s.ctrl[CTRL_RUN]),
    .in_ready(buf_in_ready),
    .in_data({(s.ptr_byte == s.sync_loc) && (s.ptr_bit == 3'h0),
      s.ctrl[CTRL_ORDER_LSB] ? ser_byte[s.ptr_bit] : ser_byte[3'h7 - s.ptr_bit]}),
    .out_valid(ser_valid),
    .out_ready(ser_ready),
    .out_data({ser_sync, ser_data})
  );

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;
  assign ber_threshold = s.ber_thr;
endmodule : wps_word_pattern_store
`default_nettype wire

// file: include/wps_pkg.sv
`default_nettype none
package wps_pkg;
  localparam int AXI_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LENGTH = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0C;
  localparam logic [7:0] REG_TOGGLE = 8'h10;
  localparam logic [7:0] REG_FILL = 8'h14;
  localparam logic [7:0] REG_CMD = 8'h18;
  localparam logic [7:0] REG_SYNC_LOC = 8'h1C;
  localparam logic [7:0] REG_BER_THR = 8'h20;
  localparam logic [7:0] REG_STATUS = 8'h24;
  localparam logic [7:0] REG_CUR_LEN = 8'h28;
  localparam int CTRL_ORDER_LSB = 0;
  localparam int CTRL_RUN = 1;
  localparam int CTRL_PART_LO = 2;
  localparam int CTRL_EXT_MEM = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] BER_THR_RST = 32'h0000_0000;
  localparam logic [16:0] SYNC_LOC_RST = 17'h00000;
  localparam int LEN_BITS_LO = 24;
  localparam int ST_SESSION = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_ERR = 2;
  localparam int ARG_LO = 4;
  localparam logic [3:0] ARG_CURRENT = 4'hF;
  localparam int NUM_SLOTS = 10;
  localparam logic [3:0] SLOTS_64K = 4'hA;
  localparam logic [3:0] SLOTS_128K = 4'h6;
  localparam logic [3:0] SLOTS_256K = 4'h3;
  localparam logic [3:0] SLOTS_512K = 4'h1;
  localparam logic [16:0] MIN_WORD_BYTES = 17'h00001;
  localparam logic [16:0] BASIC_WORD_BYTES = 17'h00002;
  localparam logic [16:0] SEG64_BYTES = 17'h02000;
  localparam logic [16:0] SEG128_BYTES = 17'h04000;
  localparam logic [16:0] SEG256_BYTES = 17'h08000;
  localparam logic [16:0] SEG512_BYTES = 17'h10000;
  localparam logic [16:0] LONG_BITS_MAX_BYTES = 17'h00800;
  localparam int MEM_BYTES = 229376;
  localparam logic [17:0] CUR_BASE = 18'h00000;
  localparam logic [17:0] SCR_BASE = 18'h10000;
  localparam logic [17:0] SAVE_BASE = 18'h20000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int SER_W = 2;
  localparam int BUF_DEPTH = 2;
  typedef struct packed {
    logic [2:0] bits;
    logic [16:0] bytes;
  } wps_len_t;
  localparam wps_len_t LEN_RST = '{bits: 3'h0, bytes: 17'h00002};
  typedef enum logic [3:0] {CMD_NONE, CMD_BEGIN, CMD_COMMIT, CMD_ABORT, CMD_SAVE, CMD_RECALL} wps_cmd_t;
  typedef enum logic {ENG_IDLE, ENG_RUN} wps_eng_t;
endpackage : wps_pkg
`default_nettype wire

// file: logic/wps_pair_buf.sv
`timescale 1ns/1ns
`default_nettype none
module wps_pair_buf #(
  parameter int W = wps_pkg::SER_W,
  parameter int DEPTH = wps_pkg::BUF_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  import wps_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] d;
    logic [$clog2(DEPTH+1)-1:0] cnt;
    logic vld;
    logic rdy;
  } wps_buf_t;

  wps_buf_t s;
  wps_buf_t next_s;
  logic push;
  logic pop;

  always_comb begin
    next_s = s;
    push = in_valid && s.rdy;
    pop = s.vld && out_ready;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_s.d[i] = s.d[i+1];
      end
      next_s.cnt = s.cnt - 1'h1;
    end
    if (push) begin
      next_s.d[next_s.cnt] = in_data;
      next_s.cnt = next_s.cnt + 1'h1;
    end
    next_s.vld = (next_s.cnt != '0);
    next_s.rdy = (next_s.cnt != ($clog2(DEPTH+1))'(DEPTH));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready = s.rdy;
  assign out_valid = s.vld;
  assign out_data = s.d[0];
endmodule : wps_pair_buf
`default_nettype wire

// file: testbench/wps_sink_model.sv
`timescale 1ns/1ns
`default_nettype none
// Serial sink on the far side; stall stretches its acceptance of bits.
module wps_sink_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ser_valid,
  input wire logic ser_data,
  input wire logic stall,
  output logic ser_ready
);
  always_ff @(posedge aclk) begin
    ser_ready <= aresetn && !stall;
  end
endmodule : wps_sink_model
`default_nettype wire

// file: testbench/wps_store_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module wps_store_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [wps_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic ser_data,
  input wire logic ser_sync,
  input wire logic ser_valid,
  input wire logic ser_ready,
  input wire logic [31:0] ber_threshold
);
  import wps_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    ##[1:2] s_axi_bvalid;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (disable iff (!aresetn) s_wr_taken |-> s_wr_answer)
    else $error("write response did not follow the write");
  a_rd_answer: assert property (disable iff (!aresetn) s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data did not follow the read address");
  a_rd_single: assert property (disable iff (!aresetn) s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while read data pending");
  a_rd_slverr: assert property (disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr > REG_CUR_LEN |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_bresp_legal: assert property (disable iff (!aresetn)
    s_axi_bvalid |-> s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR)
    else $error("write response code illegal");
  a_ser_bit_hold: assert property (disable iff (!aresetn)
    ser_valid && !ser_ready |=> ser_valid && $stable(ser_data) && $stable(ser_sync))
    else $error("serial bit changed while stalled");
  a_thr_by_write: assert property (disable iff (!aresetn)
    $changed(ber_threshold) |-> ##[0:2] s_axi_bvalid)
    else $error("threshold changed without a register write");
  a_reset_quiet: assert property (
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !ser_valid && ber_threshold == 32'h0)
    else $error("outputs not idle after reset");
endmodule : wps_store_checker
bind wps_word_pattern_store wps_store_checker i_chk (.*);
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import wps_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [AXI_AW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, ber_threshold, rv, thr;
  logic ser_data, ser_sync, ser_valid, ser_ready;
  logic stall = 1'h0, stall_en = 1'h0;
  logic [7:0] fv;
  logic [7:0] pat [2] = '{8'h25, 8'h3D};
  logic [34:0] rd_q [$];
  logic [1:0] wr_q [$];
  logic [1:0] bit_q [$];
  int bad_count = 0, checks_done = 0;
  int seed = 32'h9C0436CA;
  always #4 aclk = ~aclk;
  wps_word_pattern_store i_dut (.*);
  wps_sink_model i_sink (.aclk(aclk), .aresetn(aresetn), .ser_valid(ser_valid), .ser_data(ser_data),
    .stall(stall), .ser_ready(ser_ready));
  always @(posedge aclk) stall <= stall_en && (($random(seed) & 32'h1) != 0);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test
  // Results are compared against the oldest expectation as they appear at the ports.
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'h1 && s_axi_rready === 1'h1 && rd_q.size() > 0) begin
      if (rd_q[0][34]) begin
        check("rdata", s_axi_rdata, rd_q[0][31:0]);
        check("rresp", {30'h0, s_axi_rresp}, {30'h0, rd_q[0][33:32]});
      end
      void'(rd_q.pop_front());
    end
    if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1 && wr_q.size() > 0) begin
      check("bresp", {30'h0, s_axi_bresp}, {30'h0, wr_q.pop_front()});
    end
    if (ser_valid === 1'h1 && ser_ready === 1'h1 && bit_q.size() > 0) begin
      check("ser_data", {31'h0, ser_data}, {31'h0, bit_q[0][0]});
      check("ser_sync", {31'h0, ser_sync}, {31'h0, bit_q[0][1]});
      void'(bit_q.pop_front());
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    bit aw_ok;
    bit w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    wr_q.push_back(er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'h1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'h1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    // One idle edge keeps the next request out of this time step.
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic c = 1'h1, input logic [1:0] er = RESP_OKAY);
    rd_q.push_back({c, er, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    rv = s_axi_rdata;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask : rd
  task automatic idle;
    do rd(REG_STATUS, 32'h0, 1'h0); while (rv[ST_BUSY] !== 1'h0);
  endtask : idle
  task automatic cmd(input wps_cmd_t c, input logic [3:0] a);
    wr(REG_CMD, {24'h0, a, c});
    idle();
  endtask : cmd
  task automatic rd_byte(input logic [7:0] a, input logic [7:0] e);
    wr(REG_ADDR, {24'h0, a});
    rd(REG_DATA, {24'h0, e});
  endtask : rd_byte
  task automatic push_bits(input int nb, input logic lsb, input int sl, input int rounds);
    for (int r = 0; r < rounds; r++) begin
      for (int k = 0; k < nb; k++) begin
        for (int i = 0; i < 8; i++) begin
          bit_q.push_back({k == sl && i == 0, lsb ? pat[k][i] : pat[k][7-i]});
        end
      end
    end
  endtask : push_bits
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(REG_CTRL, CTRL_RST);
    rd(REG_CUR_LEN, 32'h2);
    rd(REG_STATUS, 32'h0);
    rd(8'h40, 32'h0, 1'h1, RESP_SLVERR);
    wr(8'h40, 32'h1, RESP_SLVERR);
    thr = $random(seed);
    wr(REG_BER_THR, thr);
    check("ber_threshold", ber_threshold, thr);
    rd(REG_BER_THR, thr);
    fv = $random(seed);
    cmd(CMD_BEGIN, ARG_CURRENT);
    wr(REG_FILL, {24'h0, fv});
    idle();
    cmd(CMD_COMMIT, ARG_CURRENT);
    rd_byte(8'h00, fv);
    rd_byte(8'h01, fv);
    cmd(CMD_BEGIN, ARG_CURRENT);
    wr(REG_ADDR, 32'h0);
    wr(REG_DATA, 32'hA5);
    wr(REG_LENGTH, 32'h1);
    cmd(CMD_ABORT, ARG_CURRENT);
    rd_byte(8'h00, fv);
    rd(REG_CUR_LEN, 32'h2);
    cmd(CMD_BEGIN, ARG_CURRENT);
    wr(REG_ADDR, 32'h0);
    wr(REG_DATA, 32'hA5);
    wr(REG_TOGGLE, 32'h1);
    wr(REG_ADDR, 32'h1);
    wr(REG_DATA, 32'h3C);
    wr(REG_TOGGLE, 32'h8);
    rd_byte(8'h00, 8'h25);
    rd_byte(8'h01, 8'h3D);
    cmd(CMD_BEGIN, ARG_CURRENT);
    rd(REG_STATUS, 32'h5);
    wr(REG_STATUS, 32'h4);
    cmd(CMD_COMMIT, ARG_CURRENT);
    cmd(CMD_SAVE, 4'h9);
    cmd(CMD_BEGIN, ARG_CURRENT);
    wr(REG_FILL, 32'h0);
    idle();
    cmd(CMD_COMMIT, ARG_CURRENT);
    cmd(CMD_RECALL, 4'h9);
    rd_byte(8'h00, 8'h25);
    cmd(CMD_SAVE, 4'hA);
    rd(REG_STATUS, 32'h4);
    wr(REG_STATUS, 32'h4);
    // Extended memory: edit addresses end at the segment size, slots follow the partition.
    wr(REG_CTRL, 32'h1 << CTRL_EXT_MEM);
    wr(REG_ADDR, 32'h2001);
    rd(REG_STATUS, 32'h4);
    wr(REG_STATUS, 32'h4);
    wr(REG_ADDR, 32'h2000);
    rd(REG_ADDR, 32'h2000);
    wr(REG_CTRL, (32'h1 << CTRL_EXT_MEM) | (32'h1 << CTRL_PART_LO));
    cmd(CMD_SAVE, 4'h6);
    rd(REG_STATUS, 32'h4);
    wr(REG_STATUS, 32'h4);
    wr(REG_ADDR, 32'h4000);
    rd(REG_ADDR, 32'h4000);
    // Stream the two-byte word MSB first with a stalling sink, sync on byte one.
    wr(REG_SYNC_LOC, 32'h1);
    stall_en = 1'h1;
    push_bits(2, 1'h0, 1, 3);
    wr(REG_CTRL, 32'h1 << CTRL_RUN);
    while (bit_q.size() > 0) @(posedge aclk);
    // Reset in mid-stream must keep the stored pattern.
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(REG_CTRL, CTRL_RST);
    cmd(CMD_BEGIN, ARG_CURRENT);
    wr(REG_LENGTH, 32'h1);
    cmd(CMD_COMMIT, ARG_CURRENT);
    rd(REG_CUR_LEN, 32'h1);
    push_bits(1, 1'h1, 0, 4);
    wr(REG_CTRL, (32'h1 << CTRL_RUN) | (32'h1 << CTRL_ORDER_LSB));
    while (bit_q.size() > 0) @(posedge aclk);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
